// ==== inc/acs_pkg.sv ====
package acs_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] OFS_CHANNEL_CTRL = 8'h00;
    localparam logic [7:0] OFS_TRIG_CMP_CTRL = 8'h04;
    localparam logic [7:0] OFS_CONV_CFG = 8'h08;
    localparam logic [7:0] OFS_CMP_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CMP_LOW = 8'h10;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h14;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h18;
    // Channel control field positions
    localparam int CH_DONE_BIT = 7;
    localparam int CH_IRQ_EN_BIT = 6;
    localparam int CH_CONT_BIT = 5;
    // Trigger and compare control field positions
    localparam int TC_ACTIVE_BIT = 7;
    localparam int TC_HW_SEL_BIT = 6;
    localparam int TC_CMP_EN_BIT = 5;
    localparam int TC_CMP_GT_BIT = 4;
    // Channel select code that disables the converter
    localparam logic [4:0] CH_DISABLED = 5'h1F;
    // Clock source codes
    localparam logic [1:0] CLK_BUS = 2'h0;
    localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
    localparam logic [1:0] CLK_ALT = 2'h2;
    localparam logic [1:0] CLK_ASYNC = 2'h3;
    // Resolution code for 10-bit conversions
    localparam logic [1:0] MODE_10BIT = 2'h2;
    // Conversion phases in converter clock cycles
    localparam logic [7:0] SMP_SHORT = 8'h04;
    localparam logic [7:0] SMP_LONG = 8'h18;
    localparam logic [7:0] BITS_8 = 8'h08;
    localparam logic [7:0] BITS_10 = 8'h0A;
    localparam logic [7:0] OVH_FIRST = 8'h08;
    localparam logic [7:0] OVH_NEXT = 8'h05;
    // Async clock startup time and its count of bus cycles
    localparam int STARTUP_NS = 5000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int STARTUP_CYC_INT = (STARTUP_NS / CLK_PERIOD_NS < 1) ? 1 : STARTUP_NS / CLK_PERIOD_NS;
    localparam logic [7:0] STARTUP_CYC = 8'(STARTUP_CYC_INT);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_STARTUP = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b011,
        ST_XFER = 3'b100
    } acs_state_e;

    typedef struct packed {
        logic low_power;
        logic [1:0] clk_div;
        logic long_sample;
        logic [1:0] mode;
        logic [1:0] clk_src;
    } acs_cfg_s;

    typedef struct packed {
        logic hw_sel;
        logic cmp_en;
        logic cmp_gt;
    } acs_trig_s;
endpackage : acs_pkg

// ==== rtl/acs_top.sv ====
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - Software write with valid channel starts conversion
// - Hardware trigger event starts conversion when selected
// - Continuous mode relaunches after every result transfer
// - Transfer sets done flag, interrupt if enabled
// - 10-bit high read blocks transfer until low
// - Blocked transfer restarts except failed single compare
// - Channel write aborts, restarts on valid channel
// - Control, config, compare writes abort conversion
// - Reset or stop without async clock aborts
// - Abort keeps results; reset restores reset values
// - Idle until start; async clock enabled then
// - Sample short or long, approximate, transfer
// - Synchronous source first conversion time bound
// - Async source adds five microsecond startup
// - Subsequent continuous conversions use shorter bound
// - Compare adds two's complement, stores difference
// - False compare: no flag, no result update
// - Wait mode lets conversions run and start
// - Bus, half bus, async clocks usable waiting
// - Completion in wait sets flag, wakes system
// - Disabled in reset and channel all ones
// - Trigger edge ignored during conversion
// - Source divided by one, two, four, eight
module acs_top
    import acs_pkg::*;
#(
    parameter int RES_W = 10
)(
    input wire logic clk_sys_i, // Bus clock
    input wire logic rstn_i, // Synchronous reset, low active
    input wire logic ce_i, // Clock enable, freezes state when low
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pwrite_i, // APB direction
    input wire logic [7:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error on unmapped address
    input wire logic hw_trigger_in_i, // Hardware trigger level
    input wire logic alternate_clock_tick_i, // Alternate clock edge strobe
    input wire logic async_clock_tick_i, // Internal async clock edge strobe
    input wire logic stop_mode_i, // System in stop mode
    input wire logic [RES_W-1:0] analog_result_i, // Converter core result
    output logic analog_sample_o, // Core samples the input
    output logic analog_convert_o, // Core runs approximation
    output logic async_clock_en_o, // Enable for internal async clock
    output logic low_power_o, // Low power configuration to core
    output logic done_irq_o // Conversion done interrupt and wake
);

    acs_state_e state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic first_r, first_nxt;
    logic pready_r, pslverr_r;
    logic [31:0] prdata_r, rd_data;
    logic irq_en_r, cont_r, done_r, blk_r, hw_prev_r, half_r;
    logic [4:0] chsel_r;
    acs_trig_s trig_r;
    acs_cfg_s cfg_r;
    logic [RES_W-1:0] cmp_r, res_r;
    logic [2:0] div_cnt_r;
    logic sample_r, convert_r, async_en_r, low_power_r, irq_r;

    // Address decode helper
    function automatic logic acs_mapped(input logic [7:0] a);
        acs_mapped = (a == OFS_CHANNEL_CTRL) || (a == OFS_TRIG_CMP_CTRL) || (a == OFS_CONV_CFG) ||
                     (a == OFS_CMP_HIGH) || (a == OFS_CMP_LOW) || (a == OFS_RESULT_HIGH) ||
                     (a == OFS_RESULT_LOW);
    endfunction : acs_mapped

    // Divider terminal count for the selected ratio
    function automatic logic [2:0] acs_div_mask(input logic [1:0] d);
        acs_div_mask = 3'((4'h1 << d) - 4'h1);
    endfunction : acs_div_mask

    // Bus strobes
    logic setup_ph, acc, wr, rd;
    assign setup_ph = psel_i & ~penable_i;
    assign acc = psel_i & penable_i & pready_r;
    assign wr = acc & pwrite_i;
    assign rd = acc & ~pwrite_i;

    logic wr_ch, wr_cfg_any, rd_hi, rd_lo, mode10;
    assign wr_ch = wr && (paddr_i == OFS_CHANNEL_CTRL);
    assign wr_cfg_any = wr && ((paddr_i == OFS_TRIG_CMP_CTRL) || (paddr_i == OFS_CONV_CFG) ||
                               (paddr_i == OFS_CMP_HIGH) || (paddr_i == OFS_CMP_LOW));
    assign rd_hi = rd && (paddr_i == OFS_RESULT_HIGH);
    assign rd_lo = rd && (paddr_i == OFS_RESULT_LOW);
    assign mode10 = (cfg_r.mode == MODE_10BIT);

    // Start and abort decisions, applied in the write cycle itself
    logic hw_rise, sw_start, hw_start, abort, start;
    assign hw_rise = hw_trigger_in_i & ~hw_prev_r;
    assign abort = wr_ch | wr_cfg_any | (chsel_r == CH_DISABLED) |
                   (stop_mode_i && (cfg_r.clk_src != CLK_ASYNC));
    assign sw_start = wr_ch && (pwdata_i[4:0] != CH_DISABLED) && !trig_r.hw_sel;
    assign hw_start = trig_r.hw_sel && hw_rise && (state_r == ST_IDLE) && !abort;
    assign start = sw_start | hw_start;

    // Converter clock: source select and divide
    logic src_tick, converter_clock_tick;
    always_comb
    begin
        case (cfg_r.clk_src)
            CLK_BUS: src_tick = 1'b1;
            CLK_BUS_DIV2: src_tick = half_r;
            CLK_ALT: src_tick = alternate_clock_tick_i;
            default: src_tick = async_clock_tick_i;
        endcase
    end
    assign converter_clock_tick = src_tick && (div_cnt_r == acs_div_mask(cfg_r.clk_div));

    // Divider counter, held cleared while idle
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            div_cnt_r <= 3'h0;
            half_r <= 1'b0;
        end
        else if (ce_i)
        begin
            if (state_r == ST_IDLE || state_r == ST_STARTUP)
            begin
                div_cnt_r <= 3'h0;
                half_r <= 1'b0;
            end
            else
            begin
                half_r <= ~half_r;
                if (converter_clock_tick)
                    div_cnt_r <= 3'h0;
                else if (src_tick)
                    div_cnt_r <= div_cnt_r + 3'h1;
            end
        end
    end

    // Compare arithmetic on the resolution in use
    logic [RES_W-1:0] conv_val, cmp_val;
    logic [RES_W:0] diff;
    logic cmp_true;
    assign conv_val = mode10 ? analog_result_i : {2'h0, analog_result_i[7:0]};
    assign cmp_val = mode10 ? cmp_r : {2'h0, cmp_r[7:0]};
    assign diff = {1'b0, conv_val} + {1'b0, ~cmp_val} + 11'h001;
    assign cmp_true = trig_r.cmp_gt ? diff[RES_W] : ~diff[RES_W];

    // Phase lengths
    logic [7:0] smp_len, cvt_len;
    assign smp_len = cfg_r.long_sample ? SMP_LONG : SMP_SHORT;
    assign cvt_len = (mode10 ? BITS_10 : BITS_8) + (first_r ? OVH_FIRST : OVH_NEXT);

    // Conversion sequencer
    logic xfer_ok;
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        first_nxt = first_r;
        xfer_ok = 1'b0;
        if (start)
        begin
            state_nxt = (cfg_r.clk_src == CLK_ASYNC) ? ST_STARTUP : ST_SAMPLE;
            cnt_nxt = 8'h00;
            first_nxt = 1'b1;
        end
        else if (abort)
        begin
            state_nxt = ST_IDLE;
            cnt_nxt = 8'h00;
        end
        else
        begin
            case (state_r)
                ST_IDLE: state_nxt = ST_IDLE;
                ST_STARTUP:
                begin
                    if (cnt_r == STARTUP_CYC - 8'h01)
                    begin
                        state_nxt = ST_SAMPLE;
                        cnt_nxt = 8'h00;
                    end
                    else
                        cnt_nxt = cnt_r + 8'h01;
                end
                ST_SAMPLE:
                begin
                    if (converter_clock_tick)
                    begin
                        if (cnt_r == smp_len - 8'h01)
                        begin
                            state_nxt = ST_CONVERT;
                            cnt_nxt = 8'h00;
                        end
                        else
                            cnt_nxt = cnt_r + 8'h01;
                    end
                end
                ST_CONVERT:
                begin
                    if (converter_clock_tick)
                    begin
                        if (cnt_r == cvt_len - 8'h01)
                        begin
                            state_nxt = ST_XFER;
                            cnt_nxt = 8'h00;
                        end
                        else
                            cnt_nxt = cnt_r + 8'h01;
                    end
                end
                ST_XFER:
                begin
                    first_nxt = 1'b0;
                    if (trig_r.cmp_en && !cmp_true)
                        state_nxt = cont_r ? ST_SAMPLE : ST_IDLE;
                    else if (blk_r)
                        state_nxt = ST_SAMPLE;
                    else
                    begin
                        xfer_ok = 1'b1;
                        state_nxt = cont_r ? ST_SAMPLE : ST_IDLE;
                    end
                end
                default:
                begin
                    state_nxt = ST_IDLE;
                    cnt_nxt = 8'h00;
                end
            endcase
        end
    end

    // Sequencer state
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 8'h00;
            first_r <= 1'b1;
            hw_prev_r <= 1'b0;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            first_r <= first_nxt;
            hw_prev_r <= hw_trigger_in_i;
        end
    end

    // Software controls
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            irq_en_r <= 1'b0;
            cont_r <= 1'b0;
            chsel_r <= CH_DISABLED;
            trig_r <= '0;
            cfg_r <= '0;
            cmp_r <= '0;
        end
        else if (ce_i && wr)
        begin
            case (paddr_i)
                OFS_CHANNEL_CTRL:
                begin
                    irq_en_r <= pwdata_i[CH_IRQ_EN_BIT];
                    cont_r <= pwdata_i[CH_CONT_BIT];
                    chsel_r <= pwdata_i[4:0];
                end
                OFS_TRIG_CMP_CTRL:
                    trig_r <= {pwdata_i[TC_HW_SEL_BIT], pwdata_i[TC_CMP_EN_BIT], pwdata_i[TC_CMP_GT_BIT]};
                OFS_CONV_CFG: cfg_r <= pwdata_i[7:0];
                OFS_CMP_HIGH: cmp_r[9:8] <= pwdata_i[1:0];
                OFS_CMP_LOW: cmp_r[7:0] <= pwdata_i[7:0];
                default: cmp_r <= cmp_r;
            endcase
        end
    end

    // Done flag: a transfer wins over a clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            done_r <= 1'b0;
        else if (ce_i)
        begin
            if (xfer_ok)
                done_r <= 1'b1;
            else if (wr_ch || rd_lo)
                done_r <= 1'b0;
        end
    end

    // Read interlock between high and low result bytes
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            blk_r <= 1'b0;
        else if (ce_i)
        begin
            if (rd_hi && mode10)
                blk_r <= 1'b1;
            else if (rd_lo)
                blk_r <= 1'b0;
        end
    end

    // Result registers, written only by a good transfer
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            res_r <= '0;
        else if (ce_i && xfer_ok)
            res_r <= trig_r.cmp_en ? diff[RES_W-1:0] : conv_val;
    end

    // Read data mux
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (paddr_i)
            OFS_CHANNEL_CTRL: rd_data[7:0] = {done_r, irq_en_r, cont_r, chsel_r};
            OFS_TRIG_CMP_CTRL: rd_data[7:0] = {state_r != ST_IDLE, trig_r, 4'h0};
            OFS_CONV_CFG: rd_data[7:0] = cfg_r;
            OFS_CMP_HIGH: rd_data[1:0] = cmp_r[9:8];
            OFS_CMP_LOW: rd_data[7:0] = cmp_r[7:0];
            OFS_RESULT_HIGH: rd_data[1:0] = res_r[9:8];
            OFS_RESULT_LOW: rd_data[7:0] = res_r[7:0];
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // APB answer registered in the setup cycle, no wait state
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            if (setup_ph)
            begin
                pready_r <= 1'b1;
                pslverr_r <= ~acs_mapped(paddr_i);
                prdata_r <= rd_data;
            end
            else if (acc)
            begin
                pready_r <= 1'b0;
                pslverr_r <= 1'b0;
            end
        end
    end

    // Registered side outputs
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
        begin
            sample_r <= 1'b0;
            convert_r <= 1'b0;
            async_en_r <= 1'b0;
            low_power_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (ce_i)
        begin
            sample_r <= (state_nxt == ST_SAMPLE);
            convert_r <= (state_nxt == ST_CONVERT);
            async_en_r <= (state_nxt != ST_IDLE) && (cfg_r.clk_src == CLK_ASYNC);
            low_power_r <= cfg_r.low_power;
            irq_r <= done_r & irq_en_r;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign analog_sample_o = sample_r;
    assign analog_convert_o = convert_r;
    assign async_clock_en_o = async_en_r;
    assign low_power_o = low_power_r;
    assign done_irq_o = irq_r;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    chk_sw_start_go: assert property (ce_i && sw_start |=> state_r == ST_SAMPLE || state_r == ST_STARTUP)
        else $error("software start not taken");
    chk_hw_start_go: assert property (ce_i && hw_start |=> state_r != ST_IDLE)
        else $error("hardware trigger start not taken");
    chk_hw_ignored: assert property (ce_i && hw_rise && state_r == ST_CONVERT && !abort
        |=> state_r != ST_SAMPLE)
        else $error("trigger edge disturbed running conversion");
    chk_done_irq: assert property (ce_i && xfer_ok && irq_en_r && !wr_ch ##1 ce_i |=> done_irq_o)
        else $error("done interrupt missing after transfer");
    chk_block_restart: assert property (ce_i && state_r == ST_XFER && blk_r && !(trig_r.cmp_en && !cmp_true)
        && !start && !abort |=> state_r == ST_SAMPLE && res_r == $past(res_r))
        else $error("blocked transfer mishandled");
    chk_abort_keeps: assert property (ce_i && abort && !start |=> state_r == ST_IDLE && res_r == $past(res_r))
        else $error("abort changed results or state");
    chk_cmp_false: assert property (ce_i && state_r == ST_XFER && trig_r.cmp_en && !cmp_true
        |=> res_r == $past(res_r))
        else $error("false compare updated result");
    chk_startup_async: assert property (state_r == ST_STARTUP |-> async_clock_en_o)
        else $error("async clock off during startup");
    chk_stop_abort: assert property (ce_i && stop_mode_i && cfg_r.clk_src != CLK_ASYNC
        |=> state_r == ST_IDLE)
        else $error("stop mode did not abort");

    cov_good_xfer: cover property (state_r == ST_XFER && xfer_ok);
    cov_blocked: cover property (state_r == ST_XFER && blk_r);
    cov_cmp_false: cover property (state_r == ST_XFER && trig_r.cmp_en && !cmp_true);
    cov_hw_start: cover property (hw_start);

endmodule : acs_top

// ==== tb/acs_core_model.sv ====
`timescale 1ns/1ps
// Behavioural analog core and clock strobes facing the sequencer
module acs_core_model (
    input wire logic clk_i, // Bus clock
    input wire logic convert_i, // Approximation running
    input wire logic async_en_i, // Async clock generator enable
    input wire logic [9:0] value_i, // Level that the core converts
    output logic [9:0] result_o, // Result towards the sequencer
    output logic async_tick_o, // Async clock strobe
    output logic alt_tick_o // Alternate clock strobe
);
    logic convert_d_r = 1'b0;
    logic tick_r = 1'b0;
    logic [1:0] div_r = 2'h0;
    logic [9:0] junk_r = 10'h2AA;
    // Delayed convert, scramble pattern, strobe generators
    always_ff @(posedge clk_i)
    begin
        convert_d_r <= convert_i;
        junk_r <= ~junk_r ^ 10'h155;
        div_r <= div_r + 2'h1;
        tick_r <= async_en_i & ~tick_r;
    end
    // Result holds through the transfer cycle, garbage otherwise
    assign result_o = (convert_i | convert_d_r) ? value_i : junk_r;
    assign async_tick_o = tick_r;
    assign alt_tick_o = (div_r == 2'h3);
endmodule : acs_core_model

// ==== tb/acs_tb_top.sv ====
`timescale 1ns/1ps
// Self-checking bench for the conversion sequencer
module acs_tb_top
    import acs_pkg::*;
;
    logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hw_trig = 1'b0, stop_mode = 1'b0, ce = 1'b1, err, saw_s, saw_c;
    logic pready, pslverr, sample, convert, async_en, low_power, done_irq, async_tick, alt_tick;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [9:0] core_val = 10'h2A5, core_res;
    logic [7:0] ab_a [4] = '{OFS_TRIG_CMP_CTRL, OFS_CONV_CFG, OFS_CMP_HIGH, OFS_CMP_LOW};
    int n_errors = 0, compares = 0, n;

    acs_top dut (.clk_sys_i(clk_sys), .rstn_i(rstn), .ce_i(ce), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .hw_trigger_in_i(hw_trig), .alternate_clock_tick_i(alt_tick),
        .async_clock_tick_i(async_tick), .stop_mode_i(stop_mode), .analog_result_i(core_res),
        .analog_sample_o(sample), .analog_convert_o(convert), .async_clock_en_o(async_en),
        .low_power_o(low_power), .done_irq_o(done_irq));

    acs_core_model core (.clk_i(clk_sys), .convert_i(convert), .async_en_i(async_en), .value_i(core_val),
        .result_o(core_res), .async_tick_o(async_tick), .alt_tick_o(alt_tick));

    // Bus clock, 25 ns period
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1)
            n_errors++;
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rdchk

    task automatic ticks(input int c);
        repeat (c) @(posedge clk_sys);
    endtask : ticks

    // Poll the done flag through the channel register
    task automatic wait_done();
        int k;
        k = 0;
        do
        begin
            apb(1'b0, OFS_CHANNEL_CTRL, 32'h0);
            k++;
        end
        while (q[7] !== 1'b1 && k < 200);
        chk(32'(q[7]), 32'h1);
    endtask : wait_done

    // Count cycles until the interrupt, noting the phases seen
    task automatic wait_irq(input int lim);
        n = 0;
        saw_s = 1'b0;
        saw_c = 1'b0;
        while (done_irq !== 1'b1 && n < lim)
        begin
            @(negedge clk_sys);
            n++;
            saw_s = saw_s | (sample === 1'b1);
            saw_c = saw_c | (saw_s & (convert === 1'b1));
        end
    endtask : wait_irq

    task automatic note(input string s);
        $display("test %0s done", s);
    endtask : note

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // Hang guard, far above the expected run length
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        close_out();
    end

    // Test sequence
    initial
    begin
        ticks(4);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rdchk(8'(4 * i), (i == 0) ? 32'h1F : 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk(32'(err), 32'h1);
        note("reset");
        wr(OFS_CHANNEL_CTRL, 32'h41);
        wait_irq(100);
        chk(32'(n <= 26), 32'h1);
        chk(32'(saw_c), 32'h1);
        rdchk(OFS_CHANNEL_CTRL, 32'hC1);
        rdchk(OFS_RESULT_LOW, 32'hA5);
        note("single");
        // Clock enable low freezes a running conversion
        wr(OFS_CHANNEL_CTRL, 32'h01);
        ce <= 1'b0;
        ticks(60);
        ce <= 1'b1;
        rdchk(OFS_TRIG_CMP_CTRL, 32'h80);
        note("freeze");
        wr(OFS_CONV_CFG, 32'h08);
        wr(OFS_CHANNEL_CTRL, 32'h01);
        apb(1'b0, OFS_RESULT_HIGH, 32'h0);
        ticks(40);
        rdchk(OFS_CHANNEL_CTRL, 32'h01);
        rdchk(OFS_TRIG_CMP_CTRL, 32'h80);
        core_val <= 10'h3C3;
        rdchk(OFS_RESULT_LOW, 32'hA5);
        wait_done();
        rdchk(OFS_RESULT_HIGH, 32'h03);
        rdchk(OFS_RESULT_LOW, 32'hC3);
        note("blocking");
        for (int i = 0; i < 4; i++)
        begin
            wr(OFS_CHANNEL_CTRL, 32'h01);
            ticks(3);
            wr(ab_a[i], (ab_a[i] == OFS_CONV_CFG) ? 32'h10 : 32'h0);
            rdchk(OFS_TRIG_CMP_CTRL, 32'h0);
        end
        rdchk(OFS_RESULT_LOW, 32'hC3);
        wr(OFS_CHANNEL_CTRL, 32'h01);
        @(posedge clk_sys);
        stop_mode <= 1'b1;
        ticks(2);
        rdchk(OFS_TRIG_CMP_CTRL, 32'h0);
        @(posedge clk_sys);
        stop_mode <= 1'b0;
        wr(OFS_CHANNEL_CTRL, 32'h1F);
        ticks(3);
        rdchk(OFS_TRIG_CMP_CTRL, 32'h0);
        note("abort");
        wr(OFS_CONV_CFG, 32'h0);
        wr(OFS_TRIG_CMP_CTRL, 32'h40);
        wr(OFS_CHANNEL_CTRL, 32'h01);
        ticks(3);
        rdchk(OFS_TRIG_CMP_CTRL, 32'h40);
        @(posedge clk_sys);
        hw_trig <= 1'b1;
        ticks(3);
        rdchk(OFS_TRIG_CMP_CTRL, 32'hC0);
        @(posedge clk_sys);
        hw_trig <= 1'b0;
        @(posedge clk_sys);
        hw_trig <= 1'b1;
        wait_done();
        ticks(5);
        rdchk(OFS_TRIG_CMP_CTRL, 32'h40);
        hw_trig <= 1'b0;
        note("trigger");
        wr(OFS_TRIG_CMP_CTRL, 32'h0);
        wr(OFS_CHANNEL_CTRL, 32'h21);
        wait_done();
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        wait_done();
        wr(OFS_CHANNEL_CTRL, 32'h1F);
        note("continuous");
        core_val <= 10'h0A5;
        wr(OFS_CMP_LOW, 32'h50);
        wr(OFS_CMP_HIGH, 32'h0);
        wr(OFS_TRIG_CMP_CTRL, 32'h30);
        wr(OFS_CHANNEL_CTRL, 32'h01);
        wait_done();
        rdchk(OFS_RESULT_LOW, 32'h55);
        wr(OFS_TRIG_CMP_CTRL, 32'h20);
        wr(OFS_CHANNEL_CTRL, 32'h01);
        ticks(40);
        rdchk(OFS_CHANNEL_CTRL, 32'h01);
        rdchk(OFS_RESULT_LOW, 32'h55);
        rdchk(OFS_TRIG_CMP_CTRL, 32'h20);
        note("compare");
        wr(OFS_TRIG_CMP_CTRL, 32'h0);
        wr(OFS_CONV_CFG, 32'h83);
        wr(OFS_CHANNEL_CTRL, 32'h41);
        ticks(2);
        @(negedge clk_sys);
        chk(32'(async_en), 32'h1);
        chk(32'(low_power), 32'h1);
        wait_irq(600);
        // Startup 200, then 20 ticks at every other cycle, plus bus overhead
        chk(32'(n <= 246), 32'h1);
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        wr(OFS_CONV_CFG, 32'h60);
        wr(OFS_CHANNEL_CTRL, 32'h41);
        wait_irq(400);
        chk(32'(n > 120 && n <= 166), 32'h1);
        // Half bus clock with long sampling, then the alternate clock
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        wr(OFS_CONV_CFG, 32'h11);
        wr(OFS_CHANNEL_CTRL, 32'h41);
        wait_irq(400);
        chk(32'(n > 60 && n <= 86), 32'h1);
        apb(1'b0, OFS_RESULT_LOW, 32'h0);
        wr(OFS_CONV_CFG, 32'h02);
        wr(OFS_CHANNEL_CTRL, 32'h41);
        wait_irq(400);
        chk(32'(n > 70 && n <= 86), 32'h1);
        note("clocking");
        close_out();
    end
endmodule : acs_tb_top
